/* core/tpisp_pkg.sv */
`default_nettype none
package tpisp_pkg;

    // Fixed upper part of the seven-bit target address
    localparam logic [2:0] ADDR_FIXED_HI = 3'h3;
    // Position of the address low nibble inside the bus config register
    localparam int CFG_ADDR_LSB = 4;
    localparam int CFG_W = 8;

    // Touch data buffer
    localparam int MEM_AW = 5;
    localparam int MEM_DEPTH = 1 << MEM_AW;
    localparam logic [MEM_AW-1:0] PTR_RESET = 5'h00;
    localparam logic [MEM_AW-1:0] PTR_ONE = 5'h01;

    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_ONE = 3'h1;
    localparam logic [2:0] BIT_RESET = 3'h0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;

    // Bus timing kept by the master; the edge detector relies on these
    localparam int CLK_PERIOD_NS = 4;
    localparam int T_BUF_NS = 4700;
    localparam int T_HD_START_NS = 4000;
    localparam int T_BUF_CYC = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_HD_START_CYC = (T_HD_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_TX_ACK = 3'b110,
        ST_TX_WAIT = 3'b111
    } tpisp_state_t;

    typedef struct packed {
        logic [MEM_AW-1:0] addr;
        logic [7:0] data;
    } tpisp_wr_t;

endpackage
`default_nettype wire

/* core/tpisp_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module tpisp_mem
    import tpisp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wrEn,
    input wire tpisp_wr_t wr,
    input wire logic [MEM_AW-1:0] rdAddr,
    output logic [7:0] rdData
);

    logic [7:0] store [MEM_DEPTH];

    // Contents carry no reset; only the read register is defined after reset
    always_ff @(posedge clk) begin
        if (wrEn) begin
            store[wr.addr] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 8'h00;
        end else begin
            rdData <= store[rdAddr];
        end
    end

endmodule // tpisp_mem
`default_nettype wire

/* core/tpisp_top.sv */
// Contract
// - Port is target only; never starts transfers nor drives the bus clock.
// - Address is fixed 3'b011 above config register bits seven to four.
// - Direction bit zero means host writes bytes, port receives them.
// - Direction bit one means port sends bytes, host receives them.
// - Both start and repeated start open an addressed packet.
// - Stop ends a packet; a new start also ends and reopens one.
// - Interrupt output tells the host touch data awaits collection.
`timescale 1ns/1ps
`default_nettype none
module tpisp_top
    import tpisp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic touchInt_b,
    input wire logic [CFG_W-1:0] touchBusConfigReg,
    input wire logic userWrValid,
    input wire tpisp_wr_t userWr,
    input wire logic touchEvent,
    output logic hostWrValid,
    output tpisp_wr_t hostWr,
    output logic busyOut
);

    // Two-stage synchronisers, one per pin; stage one feeds only stage two
    logic [1:0] pinRaw;
    logic [1:0] sync1Q;
    logic [1:0] sync2Q;
    logic [1:0] pinDlyQ;

    assign pinRaw = {sclIn, sdaIn};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gSync
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    sync1Q[gi] <= 1'b1;
                    sync2Q[gi] <= 1'b1;
                    pinDlyQ[gi] <= 1'b1;
                end else begin
                    sync1Q[gi] <= pinRaw[gi];
                    sync2Q[gi] <= sync1Q[gi];
                    pinDlyQ[gi] <= sync2Q[gi];
                end
            end
        end
    endgenerate

    wire sclS = sync2Q[1];
    wire sdaS = sync2Q[0];
    wire sclD = pinDlyQ[1];
    wire sdaD = pinDlyQ[0];
    wire sclRise = sclS & ~sclD;
    wire sclFall = ~sclS & sclD;
    // Bus minimums give a thousand or more clocks of margin, so a plain edge compare suffices
    wire startDet = sclS & sclD & sdaD & ~sdaS;
    wire stopDet = sclS & sclD & ~sdaD & sdaS;

    tpisp_state_t stateQ;
    tpisp_state_t stateD;
    logic [2:0] bitCntQ;
    logic [7:0] shiftQ;
    logic firstByteQ;
    logic [MEM_AW-1:0] ptrQ;
    logic sdaOeQ;
    logic intBQ;
    logic hostWrValidQ;
    tpisp_wr_t hostWrQ;
    logic [7:0] memRdData;

    wire [7:0] byteIn = {shiftQ[6:0], sdaS};
    wire lastBit = (bitCntQ == BIT_LAST);
    wire [6:0] ownAddr = {ADDR_FIXED_HI, touchBusConfigReg[CFG_ADDR_LSB +: 4]};
    wire addrMatch = (byteIn[7:1] == ownAddr);
    wire readMatch = (stateQ == ST_ADDR) & sclRise & lastBit & addrMatch & byteIn[0];
    wire rxDone = (stateQ == ST_RX) & sclRise & lastBit;
    wire ptrStep = (rxDone & ~firstByteQ) | ((stateQ == ST_TX) & sclRise & lastBit);

    tpisp_mem uMem (
        .clk(clk),
        .rst_b(rst_b),
        .wrEn(userWrValid),
        .wr(userWr),
        .rdAddr(ptrQ),
        .rdData(memRdData)
    );

    // Next state
    always_comb begin
        stateD = stateQ;
        if (startDet) begin
            stateD = ST_ADDR;
        end else if (stopDet) begin
            stateD = ST_IDLE;
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    stateD = ST_IDLE;
                end
                ST_ADDR: begin
                    if (sclRise && lastBit) begin
                        // Other targets' packets are ignored until the next start
                        stateD = addrMatch ? ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall && sdaOeQ) begin
                        stateD = shiftQ[0] ? ST_TX : ST_RX;
                    end
                end
                ST_RX: begin
                    if (rxDone) begin
                        stateD = ST_RX_ACK;
                    end
                end
                ST_RX_ACK: begin
                    if (sclFall && sdaOeQ) begin
                        stateD = ST_RX;
                    end
                end
                ST_TX: begin
                    if (sclRise && lastBit) begin
                        stateD = ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    // Host acknowledge keeps the read going; a refusal ends it
                    if (sclRise) begin
                        stateD = sdaS ? ST_IDLE : ST_TX_WAIT;
                    end
                end
                ST_TX_WAIT: begin
                    if (sclFall) begin
                        stateD = ST_TX;
                    end
                end
                default: begin
                    stateD = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= ST_IDLE;
        end else begin
            stateQ <= stateD;
        end
    end

    // Bit counter and shift register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bitCntQ <= BIT_RESET;
            shiftQ <= SHIFT_RESET;
        end else if (startDet || stopDet) begin
            bitCntQ <= BIT_RESET;
        end else if ((stateQ == ST_ADDR || stateQ == ST_RX) && sclRise) begin
            bitCntQ <= bitCntQ + BIT_ONE;
            shiftQ <= byteIn;
        end else if (stateQ == ST_TX && sclRise) begin
            bitCntQ <= bitCntQ + BIT_ONE;
        end else if (stateQ == ST_TX && sclFall) begin
            shiftQ <= {shiftQ[6:0], 1'b0};
        end else if (sclFall && ((stateQ == ST_ADDR_ACK && sdaOeQ && shiftQ[0]) || stateQ == ST_TX_WAIT)) begin
            bitCntQ <= BIT_RESET;
            shiftQ <= memRdData;
        end else if (sclFall && sdaOeQ && (stateQ == ST_ADDR_ACK || stateQ == ST_RX_ACK)) begin
            bitCntQ <= BIT_RESET;
        end
    end

    // Data line drive: acknowledge after received bytes, data bits while sending
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdaOeQ <= 1'b0;
        end else if (startDet || stopDet) begin
            sdaOeQ <= 1'b0;
        end else if (sclFall) begin
            case (stateQ)
                ST_ADDR_ACK: sdaOeQ <= sdaOeQ ? (shiftQ[0] & ~memRdData[7]) : 1'b1;
                ST_RX_ACK: sdaOeQ <= ~sdaOeQ;
                ST_TX: sdaOeQ <= (bitCntQ == BIT_RESET) ? 1'b0 : ~shiftQ[6];
                ST_TX_WAIT: sdaOeQ <= ~memRdData[7];
                default: sdaOeQ <= 1'b0;
            endcase
        end
    end

    // Pointer: first written byte selects it, later bytes and reads advance it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptrQ <= PTR_RESET;
            firstByteQ <= 1'b0;
        end else if (stateQ == ST_ADDR && sclRise && lastBit && addrMatch) begin
            firstByteQ <= ~byteIn[0];
        end else if (rxDone && firstByteQ) begin
            ptrQ <= byteIn[MEM_AW-1:0];
            firstByteQ <= 1'b0;
        end else if (ptrStep) begin
            ptrQ <= ptrQ + PTR_ONE;
        end
    end

    // Host writes after the pointer byte leave the port as strobes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hostWrValidQ <= 1'b0;
            hostWrQ <= '0;
        end else begin
            hostWrValidQ <= rxDone & ~firstByteQ;
            if (rxDone && !firstByteQ) begin
                hostWrQ <= '{addr: ptrQ, data: byteIn};
            end
        end
    end

    // A new touch event wins over the clear made by a read addressing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            intBQ <= 1'b1;
        end else if (touchEvent) begin
            intBQ <= 1'b0;
        end else if (readMatch) begin
            intBQ <= 1'b1;
        end
    end

    logic busyQ;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busyQ <= 1'b0;
        end else begin
            busyQ <= (stateD != ST_IDLE) && (stateD != ST_ADDR);
        end
    end

    // Open-drain: only ever pull low
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOeQ;
    assign touchInt_b = intBQ;
    assign hostWrValid = hostWrValidQ;
    assign hostWr = hostWrQ;
    assign busyOut = busyQ;

endmodule // tpisp_top
`default_nettype wire

/* verification/tpisp_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tpisp_properties (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic touchInt_b,
    input wire logic touchEvent,
    input wire logic hostWrValid,
    input wire logic busyOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Raw pins lead the synchroniser, so bus events get a few cycles of slack
    pull_low_a: assert property (sdaOut == 1'b0) else $error("sda driven high");
    ack_busy_a: assert property (sdaOe |-> busyOut) else $error("sda pulled while idle");
    wr_pulse_a: assert property (hostWrValid |=> !hostWrValid) else $error("long write strobe");
    wr_busy_a: assert property (hostWrValid |-> busyOut) else $error("strobe while idle");
    start_reopen_a: assert property (sclIn && $fell(sdaIn) |-> ##[1:6] !busyOut) else $error("start ignored");
    stop_idle_a: assert property (sclIn && $rose(sdaIn) |-> ##[1:6] !busyOut) else $error("stop ignored");
    int_set_a: assert property (touchEvent |=> !touchInt_b) else $error("event lost");
    int_clear_a: assert property ($rose(touchInt_b) |-> busyOut) else $error("interrupt dropped");
    // A data change while the clock is high would look like a start or stop to every other target
    sda_hold_a: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("sda moved, clock high");
    cover property (hostWrValid);
    cover property ($rose(touchInt_b));
    cover property (sdaOe && !sdaIn);
endmodule // tpisp_properties
bind tpisp_top tpisp_properties tpisp_properties_inst (.clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .touchInt_b(touchInt_b), .touchEvent(touchEvent),
    .hostWrValid(hostWrValid), .busyOut(busyOut));
`default_nettype wire

/* verification/tpisp_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module tpisp_mst (
    input wire logic clk,
    input wire logic sda,
    output var logic scl,
    output var logic sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Works from idle and mid-packet alike
    task automatic start();
        sdaLow = 1'b0;
        w(20);
        scl = 1'b1;
        w(1175);
        sdaLow = 1'b1;
        w(1000);
        scl = 1'b0;
    endtask
    task automatic stop();
        sdaLow = 1'b1;
        w(20);
        scl = 1'b1;
        w(1000);
        sdaLow = 1'b0;
        w(1175);
    endtask
    // Eight bits MSB first, then the acknowledge slot; a one releases the line
    task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
        logic [8:0] o;
        for (int i = 8; i >= 0; i--) begin
            sdaLow = !(i > 0 ? d[i-1] : a);
            w(20);
            scl = 1'b1;
            w(10);
            o[i] = sda;
            w(10);
            scl = 1'b0;
        end
        q = o[8:1];
        r = o[0];
    endtask
endmodule // tpisp_mst
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import tpisp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [CFG_W-1:0] cfg = 8'ha5;
    logic userWrValid = 1'b0;
    tpisp_wr_t userWr = '0;
    logic touchEvent = 1'b0;
    wire logic scl, sdaLow, sdaOut, sdaOe, touchInt_b, hostWrValid, busyOut;
    tpisp_wr_t hostWr;
    wire logic sda = !(sdaLow || sdaOe);
    int error_cnt = 0;
    int compares = 0;
    int wrPulses = 0;
    logic [7:0] q;
    logic r;
    tpisp_top tpisp_top_inst (.clk(clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .touchInt_b(touchInt_b), .touchBusConfigReg(cfg), .userWrValid(userWrValid),
        .userWr(userWr), .touchEvent(touchEvent), .hostWrValid(hostWrValid), .hostWr(hostWr), .busyOut(busyOut));
    tpisp_mst tpisp_mst_inst (.clk(clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
    always #2 clk = ~clk;
    // Strobes are counted away from the edge that launches them
    always @(negedge clk) begin
        if (hostWrValid === 1'b1) begin
            wrPulses++;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic xb(input logic [7:0] d, input logic a);
        tpisp_mst_inst.xbyte(d, a, q, r);
    endtask
    task automatic t_write();
        tpisp_mst_inst.start();
        xb({7'h3a, 1'b0}, 1'b1);
        chk(r, 1'b0);
        xb(8'h04, 1'b1);
        xb(8'h5c, 1'b1);
        chk({r, hostWr}, {1'b0, 5'h04, 8'h5c});
        xb(8'h3e, 1'b1);
        chk(hostWr, {5'h05, 8'h3e});
        chk(16'(wrPulses), 16'h0002);
        tpisp_mst_inst.stop();
        chk(busyOut, 1'b0);
        $display("write test done");
    endtask
    task automatic t_read();
        @(negedge clk);
        userWr = {5'h06, 8'h96};
        userWrValid = 1'b1;
        @(negedge clk);
        userWr = {5'h07, 8'h1f};
        touchEvent = 1'b1;
        @(negedge clk);
        userWrValid = 1'b0;
        touchEvent = 1'b0;
        chk(touchInt_b, 1'b0);
        tpisp_mst_inst.start();
        xb({7'h3a, 1'b0}, 1'b1);
        xb(8'h06, 1'b1);
        // No stop: the second start closes the pointer write
        tpisp_mst_inst.start();
        xb({7'h3a, 1'b1}, 1'b1);
        chk({r, touchInt_b}, 2'b01);
        xb(8'hff, 1'b0);
        chk(q, 8'h96);
        xb(8'hff, 1'b1);
        chk(q, 8'h1f);
        tpisp_mst_inst.stop();
        chk(16'(wrPulses), 16'h0002);
        $display("read test done");
    endtask
    task automatic t_addr();
        tpisp_mst_inst.start();
        xb({7'h35, 1'b0}, 1'b1);
        chk(r, 1'b1);
        tpisp_mst_inst.start();
        xb({7'h7a, 1'b1}, 1'b1);
        chk(r, 1'b1);
        cfg = 8'hf0;
        tpisp_mst_inst.start();
        xb({7'h3f, 1'b0}, 1'b1);
        chk(r, 1'b0);
        tpisp_mst_inst.stop();
        $display("address test done");
    endtask
    task automatic t_reset();
        @(negedge clk);
        touchEvent = 1'b1;
        @(negedge clk);
        touchEvent = 1'b0;
        chk(touchInt_b, 1'b0);
        rst_b = 1'b0;
        @(negedge clk);
        chk({touchInt_b, busyOut, sdaOe, hostWrValid, sdaOut}, 5'h10);
        chk(hostWr, 13'h0000);
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        chk({touchInt_b, busyOut}, 2'h2);
        $display("reset test done");
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_write();
        t_read();
        t_addr();
        t_reset();
        stop_test();
    end
    initial begin
        #250000;
        error_cnt++;
        stop_test();
    end
endmodule // testbench
`default_nettype wire
